// ---- logic/csor_pkg.sv ----
// package: register map, field layout and constants for status/option bank
package csor_pkg;
  localparam logic [7:0] CSOR_STATUS_ADDR = 8'h03;
  localparam logic [7:0] CSOR_STATUS_ADDR_HI = 8'h83;
  localparam logic [7:0] CSOR_OPTION_ADDR = 8'h81;
  localparam logic [7:0] CSOR_TMR_ADDR = 8'h01;
  // status field positions
  localparam int CSOR_C = 0;
  localparam int CSOR_NIBC = 1;
  localparam int CSOR_Z = 2;
  localparam int CSOR_PWRDN = 3;
  localparam int CSOR_TMOUT = 4;
  localparam int CSOR_BANK_LO = 5;
  localparam int CSOR_BANK_HI = 6;
  localparam int CSOR_BANK_IND = 7;
  // option field positions
  localparam int CSOR_PS_LO = 0;
  localparam int CSOR_PSC_SEL = 3;
  localparam int CSOR_TSE = 4;
  localparam int CSOR_TCS = 5;
  localparam int CSOR_EDG = 6;
  localparam int CSOR_PUD = 7;
  localparam logic [7:0] CSOR_OPTION_RST = 8'hFF;
  localparam logic [7:0] CSOR_ZERO8 = 8'h00;
  localparam logic [7:0] CSOR_ONE8 = 8'h01;
  localparam logic [1:0] CSOR_QUARTER_MAX = 2'h3;
  localparam logic [2:0] CSOR_ONE3 = 3'h1;
  // alu operation classes seen by the flag logic; CSOR_OP_NONE leaves the flags alone
  typedef enum logic [2:0] {
    CSOR_OP_NONE,
    CSOR_OP_LOGIC,
    CSOR_OP_ADD,
    CSOR_OP_SUB,
    CSOR_OP_ROTL,
    CSOR_OP_ROTR
  } csor_op_t;
endpackage

// ---- logic/csor_prescaler.sv ----
// shared 8-bit prescaler with timer/watchdog tap selection
`timescale 1ns/1ps
module csor_prescaler
  import csor_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic assign_wdt,
  input wire logic [2:0] rate,
  input wire logic clear,
  input wire logic tick_in,
  // result
  output logic tick_out
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [3:0] shift;
  logic [8:0] mask;

  always_comb begin
    next_count = count + CSOR_ONE8;
    // timer divides by 2^(rate+1), watchdog by 2^rate
    shift = assign_wdt ? {1'b0, rate} : {1'b0, rate} + 4'h1;
    // nine bits so that a shift of eight still gives an all-ones byte
    mask = (9'h001 << shift) - 9'h001;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clear) begin
      count <= CSOR_ZERO8;
    end else if (tick_in && !(assign_wdt && rate == 3'h0)) begin
      count <= next_count;
    end
  end

  // a tap fires when the low 'shift' bits roll over to zero
  always_comb begin
    tick_out = 1'b0;
    if (tick_in) begin
      if (shift == 4'h0) begin
        tick_out = 1'b1;
      end else begin
        tick_out = (next_count & mask[7:0]) == CSOR_ZERO8;
      end
    end
  end
endmodule

// ---- logic/csor_regs.sv ----
// core status and option register bank with timebase counter path
`timescale 1ns/1ps
module csor_regs
  import csor_pkg::*;
(
  // oscillator-rate clock and synchronous reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic external_reset_n,
  // core register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata,
  // alu result for flag update
  input wire csor_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_cin,
  output logic [7:0] alu_result,
  // power events
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic wdt_timeout,
  input wire logic wdt_base_tick,
  // pins
  input wire logic timer_clock_pin,
  input wire logic ext_irq_pin,
  // outputs to neighbours
  output logic instr_clk_en,
  output logic bank_select_low,
  output logic [7:0] data_addr_base,
  output logic portb_pullup_en,
  output logic ext_irq_event,
  output logic wdt_tick,
  output logic [7:0] timebase_counter
);
  logic [7:0] core_status;
  logic [7:0] core_options;
  logic [1:0] quarter;
  logic rst;
  logic rst_s1;
  logic rst_s2;
  logic tpin_s1;
  logic tpin_s2;
  logic tpin_d;
  logic irq_s1;
  logic irq_s2;
  logic irq_d;
  logic timer_src_tick;
  logic psc_in;
  logic psc_out;
  logic psc_clear;
  logic tmr_write;
  logic stat_write;
  logic opt_write;
  logic [8:0] sum;
  logic [4:0] nib;
  logic next_c;
  logic next_nibc;
  logic flag_op;
  logic indirect_bank_bit;
  logic bank_select_high;
  logic zero_flag;
  logic nibble_overflow_flag;
  logic carry_flag;
  logic watchdog_timeout_flag;
  logic powerdown_flag;

  ////////////////////////////////////////////////////////////////////////
  // reset and pin synchronisers

  always_ff @(posedge mclk) begin
    rst_s1 <= ~external_reset_n;
    rst_s2 <= rst_s1;
  end
  assign rst = sys_rst | rst_s2;

  always_ff @(posedge mclk) begin
    tpin_s1 <= timer_clock_pin;
    tpin_s2 <= tpin_s1;
    tpin_d <= tpin_s2;
    irq_s1 <= ext_irq_pin;
    irq_s2 <= irq_s1;
    irq_d <= irq_s2;
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction cycle divider: one enable per four oscillator clocks

  always_ff @(posedge mclk) begin
    if (rst) begin
      quarter <= 2'h0;
    end else begin
      quarter <= quarter + 2'h1;
    end
  end
  assign instr_clk_en = (quarter == CSOR_QUARTER_MAX);

  ////////////////////////////////////////////////////////////////////////
  // alu flag generation

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    alu_result = alu_a;
    next_c = carry_flag;
    next_nibc = nibble_overflow_flag;
    flag_op = 1'b1;
    unique case (alu_op)
      CSOR_OP_ADD: begin
        sum = {1'b0, alu_a} + {1'b0, alu_b};
        nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        alu_result = sum[7:0];
        next_c = sum[8];
        next_nibc = nib[4];
      end
      CSOR_OP_SUB: begin
        // two's complement add; carry high means no borrow
        sum = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
        nib = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
        alu_result = sum[7:0];
        next_c = sum[8];
        next_nibc = nib[4];
      end
      CSOR_OP_ROTL: begin
        alu_result = {alu_a[6:0], alu_cin};
        next_c = alu_a[7];
      end
      CSOR_OP_ROTR: begin
        alu_result = {alu_cin, alu_a[7:1]};
        next_c = alu_a[0];
      end
      CSOR_OP_LOGIC: begin
        alu_result = alu_b;
      end
      CSOR_OP_NONE: begin
        flag_op = 1'b0;
      end
      default: begin
        flag_op = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode

  // status answers at both bank mirrors
  function automatic logic is_status(input logic [7:0] addr);
    return addr == CSOR_STATUS_ADDR || addr == CSOR_STATUS_ADDR_HI;
  endfunction

  assign stat_write = reg_we && is_status(reg_addr);
  assign opt_write = reg_we && reg_addr == CSOR_OPTION_ADDR;
  assign tmr_write = reg_we && reg_addr == CSOR_TMR_ADDR;

  always_comb begin
    if (is_status(reg_addr)) begin
      reg_rdata = core_status;
    end else if (reg_addr == CSOR_OPTION_ADDR) begin
      reg_rdata = core_options;
    end else if (reg_addr == CSOR_TMR_ADDR) begin
      reg_rdata = timebase_counter;
    end else begin
      reg_rdata = CSOR_ZERO8;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register

  // bank bits, set only by a status write
  always_ff @(posedge mclk) begin
    if (rst) begin
      indirect_bank_bit <= 1'b0;
      bank_select_high <= 1'b0;
      bank_select_low <= 1'b0;
    end else if (stat_write) begin
      indirect_bank_bit <= reg_wdata[CSOR_BANK_IND];
      bank_select_high <= reg_wdata[CSOR_BANK_HI];
      bank_select_low <= reg_wdata[CSOR_BANK_LO];
    end
  end

  // arithmetic flags: the operation wins over a direct write
  always_ff @(posedge mclk) begin
    if (rst) begin
      zero_flag <= 1'b0;
      nibble_overflow_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (flag_op) begin
      zero_flag <= (alu_result == CSOR_ZERO8);
      nibble_overflow_flag <= next_nibc;
      carry_flag <= next_c;
    end else if (stat_write) begin
      zero_flag <= reg_wdata[CSOR_Z];
      nibble_overflow_flag <= reg_wdata[CSOR_NIBC];
      carry_flag <= reg_wdata[CSOR_C];
    end
  end

  // timeout and powerdown: hardware only, software writes dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      watchdog_timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else begin
      if (wdt_timeout) begin
        watchdog_timeout_flag <= 1'b0;
      end else if (watchdog_clear_instr || sleep_instr) begin
        watchdog_timeout_flag <= 1'b1;
      end
      if (sleep_instr) begin
        powerdown_flag <= 1'b0;
      end else if (watchdog_clear_instr) begin
        powerdown_flag <= 1'b1;
      end
    end
  end

  // each flag group has its own owner process; the byte is only a read view
  always_comb begin
    core_status = CSOR_ZERO8;
    core_status[CSOR_BANK_IND] = indirect_bank_bit;
    core_status[CSOR_BANK_HI] = bank_select_high;
    core_status[CSOR_BANK_LO] = bank_select_low;
    core_status[CSOR_TMOUT] = watchdog_timeout_flag;
    core_status[CSOR_PWRDN] = powerdown_flag;
    core_status[CSOR_Z] = zero_flag;
    core_status[CSOR_NIBC] = nibble_overflow_flag;
    core_status[CSOR_C] = carry_flag;
  end

  assign data_addr_base = {bank_select_low, 7'h00};

  ////////////////////////////////////////////////////////////////////////
  // option register

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_options <= CSOR_OPTION_RST;
    end else if (opt_write) begin
      core_options <= reg_wdata;
    end
  end

  assign portb_pullup_en = ~core_options[CSOR_PUD];

  // external interrupt edge detect on synchronised pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_irq_event <= 1'b0;
    end else if (core_options[CSOR_EDG]) begin
      ext_irq_event <= irq_s2 & ~irq_d;
    end else begin
      ext_irq_event <= ~irq_s2 & irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase source, shared prescaler and counter

  always_comb begin
    if (core_options[CSOR_TCS]) begin
      if (core_options[CSOR_TSE]) begin
        timer_src_tick = ~tpin_s2 & tpin_d;
      end else begin
        timer_src_tick = tpin_s2 & ~tpin_d;
      end
    end else begin
      timer_src_tick = instr_clk_en;
    end
  end

  // the prescaler serves exactly one consumer at a time
  assign psc_in = core_options[CSOR_PSC_SEL] ? wdt_base_tick
                                             : timer_src_tick;
  assign psc_clear = core_options[CSOR_PSC_SEL] ? watchdog_clear_instr
                                                : tmr_write;

  csor_prescaler u_psc (
    .mclk(mclk),
    .sys_rst(rst),
    .assign_wdt(core_options[CSOR_PSC_SEL]),
    .rate(core_options[CSOR_PS_LO +: 3]),
    .clear(psc_clear),
    .tick_in(psc_in),
    .tick_out(psc_out)
  );

  assign wdt_tick = core_options[CSOR_PSC_SEL] ? psc_out : wdt_base_tick;

  always_ff @(posedge mclk) begin
    if (rst) begin
      timebase_counter <= CSOR_ZERO8;
    end else if (tmr_write) begin
      timebase_counter <= reg_wdata;
    end else if (core_options[CSOR_PSC_SEL] ? timer_src_tick : psc_out) begin
      timebase_counter <= timebase_counter + CSOR_ONE8;
    end
  end
endmodule

// ---- verification/csor_regs_assertions.sv ----
// checker: port-level properties of the status/option bank
`timescale 1ns/1ps
module csor_regs_assertions
  import csor_pkg::*;
(
  // clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic external_reset_n,
  // register and alu side
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic [7:0] reg_rdata,
  input wire csor_op_t alu_op,
  input wire logic [7:0] alu_result,
  // power events
  input wire logic sleep_instr,
  input wire logic wdt_timeout,
  input wire logic wdt_base_tick,
  // outputs
  input wire logic instr_clk_en,
  input wire logic bank_select_low,
  input wire logic [7:0] data_addr_base,
  input wire logic portb_pullup_en,
  input wire logic wdt_tick,
  input wire logic [7:0] timebase_counter
);
  logic [2:0] xr;
  logic [7:0] opt;
  // the pin reset reaches the core late, so stay quiet a few edges more
  wire hold = !external_reset_n || (xr != 3'h0);
  always_ff @(posedge mclk) begin
    xr <= {xr[1:0], !external_reset_n};
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || hold) begin
      opt <= CSOR_OPTION_RST;
    end else if (reg_we && reg_addr == CSOR_OPTION_ADDR) begin
      opt <= reg_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || hold);
  ////////////////////////////////////////////////////////////////////////
  a_pullup_ctrl:
    assert property (reg_we && reg_addr == CSOR_OPTION_ADDR |=>
      portb_pullup_en == !$past(reg_wdata[CSOR_PUD])) else $error("pullup");
  a_bank_write:
    assert property (reg_we && reg_addr == CSOR_STATUS_ADDR |=>
      bank_select_low == $past(reg_wdata[CSOR_BANK_LO]) &&
      data_addr_base == {bank_select_low, 7'h00}) else $error("bank");
  a_instr_quarter:
    assert property (instr_clk_en |=> !instr_clk_en [*3] ##1 instr_clk_en)
    else $error("instruction clock rate");
  a_wdt_direct:
    assert property (!opt[CSOR_PSC_SEL] |-> wdt_tick == wdt_base_tick)
    else $error("watchdog tick");
  a_tmr_unscaled:
    assert property (instr_clk_en && opt[CSOR_PSC_SEL] && !opt[CSOR_TCS] &&
      !(reg_we && reg_addr == CSOR_TMR_ADDR) |=>
      timebase_counter == $past(timebase_counter) + 8'h01) else $error("tmr");
  a_sleep_pwrdn:
    assert property (sleep_instr ##1 reg_addr == CSOR_STATUS_ADDR |->
      !reg_rdata[CSOR_PWRDN]) else $error("powerdown flag");
  a_timeout_clr:
    assert property (wdt_timeout ##1 reg_addr == CSOR_STATUS_ADDR |->
      !reg_rdata[CSOR_TMOUT]) else $error("timeout flag");
  a_zero_flag:
    assert property (alu_op inside {CSOR_OP_LOGIC, CSOR_OP_ADD, CSOR_OP_SUB}
      ##1 reg_addr == CSOR_STATUS_ADDR |-> reg_rdata[CSOR_Z] ==
      ($past(alu_result) == CSOR_ZERO8)) else $error("zero flag");
endmodule
bind csor_regs csor_regs_assertions csor_regs_assertions_i (.mclk,
  .sys_rst, .external_reset_n, .reg_addr, .reg_wdata, .reg_we, .reg_rdata,
  .alu_op, .alu_result, .sleep_instr, .wdt_timeout, .wdt_base_tick,
  .instr_clk_en, .bank_select_low, .data_addr_base, .portb_pullup_en,
  .wdt_tick, .timebase_counter);

// ---- verification/csor_regs_tb.sv ----
// testbench: directed scenarios for the status/option bank
`timescale 1ns/1ps
module csor_regs_tb;
  import csor_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic external_reset_n = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00, reg_rdata, alu_result, data_addr_base;
  logic [7:0] timebase_counter;
  logic reg_we = 1'b0, alu_cin = 1'b0, watchdog_clear_instr = 1'b0;
  logic sleep_instr = 1'b0, wdt_timeout = 1'b0, wdt_base_tick = 1'b0;
  logic timer_clock_pin = 1'b0, ext_irq_pin = 1'b0;
  logic instr_clk_en, bank_select_low, portb_pullup_en, ext_irq_event;
  logic wdt_tick;
  csor_op_t alu_op = CSOR_OP_NONE;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  csor_regs csor_regs_i (
    .mclk(mclk), .sys_rst(sys_rst), .external_reset_n(external_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .alu_cin(alu_cin), .alu_result(alu_result),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
    .wdt_timeout(wdt_timeout), .wdt_base_tick(wdt_base_tick),
    .timer_clock_pin(timer_clock_pin), .ext_irq_pin(ext_irq_pin),
    .instr_clk_en(instr_clk_en), .bank_select_low(bank_select_low),
    .data_addr_base(data_addr_base), .portb_pullup_en(portb_pullup_en),
    .ext_irq_event(ext_irq_event), .wdt_tick(wdt_tick),
    .timebase_counter(timebase_counter)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      test_done;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    @(negedge mclk);
    reg_addr = a;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic alu(input csor_op_t o, input logic [7:0] a, b,
    input logic w, input logic [7:0] r, m, e);
    @(negedge mclk);
    alu_op = o;
    alu_a = a;
    alu_b = b;
    alu_cin = b[0];
    reg_addr = CSOR_STATUS_ADDR;
    reg_wdata = 8'h03;
    reg_we = w;
    #1 chk(alu_result, r);
    @(negedge mclk);
    alu_op = CSOR_OP_NONE;
    reg_we = 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic pwr(input int k, input logic [7:0] e);
    @(negedge mclk);
    case (k)
      0: watchdog_clear_instr = 1'b1;
      1: sleep_instr = 1'b1;
      default: wdt_timeout = 1'b1;
    endcase
    @(negedge mclk);
    {watchdog_clear_instr, sleep_instr, wdt_timeout} = 3'h0;
    reg_addr = CSOR_STATUS_ADDR;
    #1 chk(reg_rdata & 8'h18, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(CSOR_STATUS_ADDR, 8'hFF, 8'h18);
    rd(CSOR_OPTION_ADDR, 8'hFF, 8'hFF);
    wr(CSOR_OPTION_ADDR, 8'h5A);
    rd(CSOR_OPTION_ADDR, 8'hFF, 8'h5A);
    chk({7'h00, portb_pullup_en}, 8'h01);
    wr(CSOR_OPTION_ADDR, 8'hA5);
    rd(CSOR_OPTION_ADDR, 8'hFF, 8'hA5);
    chk({7'h00, portb_pullup_en}, 8'h00);
    rd(8'h55, 8'hFF, 8'h00);
    wr(CSOR_STATUS_ADDR, 8'h27);
    rd(CSOR_STATUS_ADDR_HI, 8'hFF, 8'h3F);
    chk(data_addr_base, 8'h80);
    wr(CSOR_STATUS_ADDR, 8'h00);
    rd(CSOR_STATUS_ADDR, 8'hFF, 8'h18);
  endtask
  task automatic t_alu;
    alu(CSOR_OP_LOGIC, 8'h00, 8'h00, 1'b1, 8'h00, 8'h07, 8'h04);
    alu(CSOR_OP_ADD, 8'h0F, 8'h01, 1'b0, 8'h10, 8'h07, 8'h02);
    alu(CSOR_OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h07, 8'h07);
    alu(CSOR_OP_SUB, 8'h05, 8'h03, 1'b0, 8'h02, 8'h07, 8'h03);
    alu(CSOR_OP_SUB, 8'h03, 8'h05, 1'b0, 8'hFE, 8'h07, 8'h00);
    alu(CSOR_OP_ROTL, 8'h80, 8'h00, 1'b0, 8'h00, 8'h01, 8'h01);
    alu(CSOR_OP_ROTR, 8'h02, 8'h01, 1'b0, 8'h81, 8'h01, 8'h00);
    pwr(1, 8'h10);
    pwr(2, 8'h00);
    pwr(0, 8'h18);
  endtask
  task automatic t_timer;
    wr(CSOR_OPTION_ADDR, 8'h08);
    wr(CSOR_TMR_ADDR, 8'h00);
    repeat (40) @(negedge mclk);
    chk(timebase_counter, 8'h0A);
    for (int p = 0; p < 3; p++) begin
      wr(CSOR_OPTION_ADDR, {5'h00, p[2:0]});
      wr(CSOR_TMR_ADDR, 8'h00);
      repeat (40 << p) @(negedge mclk);
      chk(timebase_counter, 8'h05);
    end
    for (int s = 0; s < 2; s++) begin
      timer_clock_pin = 1'b0;
      wr(CSOR_OPTION_ADDR, s[0] ? 8'h38 : 8'h28);
      repeat (4) @(negedge mclk);
      wr(CSOR_TMR_ADDR, 8'h00);
      repeat (7) begin
        repeat (6) @(negedge mclk);
        timer_clock_pin = ~timer_clock_pin;
      end
      repeat (6) @(negedge mclk);
      chk(timebase_counter, s[0] ? 8'h03 : 8'h04);
    end
  endtask
  task automatic t_wdt_irq;
    logic [7:0] ov[3] = '{8'h00, 8'h08, 8'h0A};
    logic [7:0] ev[3] = '{8'h08, 8'h08, 8'h02};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(CSOR_OPTION_ADDR, ov[i]);
      pwr(0, 8'h18);
      n = 0;
      repeat (8) begin
        @(negedge mclk);
        wdt_base_tick = 1'b1;
        #1 if (wdt_tick === 1'b1) n++;
        @(negedge mclk);
        wdt_base_tick = 1'b0;
      end
      chk(n[7:0], ev[i]);
    end
    for (int s = 0; s < 2; s++) begin
      wr(CSOR_OPTION_ADDR, {1'b1, s[0], 6'h3F});
      n = 0;
      for (int h = 0; h < 2; h++) begin
        ext_irq_pin = ~ext_irq_pin;
        repeat (8) begin
          @(negedge mclk);
          if (ext_irq_event === 1'b1) n++;
        end
        if (h == 0) chk(n[7:0], {7'h00, s[0]});
      end
      chk(n[7:0], 8'h01);
    end
    // leave non-reset values behind so the pin reset has something to undo
    wr(CSOR_OPTION_ADDR, 8'h00);
    wr(CSOR_STATUS_ADDR, 8'h27);
    @(negedge mclk);
    external_reset_n = 1'b0;
    repeat (4) @(negedge mclk);
    external_reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(CSOR_OPTION_ADDR, 8'hFF, 8'hFF);
    rd(CSOR_STATUS_ADDR, 8'hFF, 8'h18);
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_regs;
    t_alu;
    t_timer;
    t_wdt_irq;
    test_done;
  end
endmodule
